// ==== design/avr_defines.svh ====
`ifndef AVR_DEFINES_SVH
`define AVR_DEFINES_SVH
// ==========================================================
// Register offsets
`define AVR_OFS_VOL_B        8'h3D
`define AVR_OFS_VOL_A        8'h3E
`define AVR_OFS_RAMP_CFG     8'h3F
`define AVR_OFS_EMRG_CFG     8'h40
// ==========================================================
// Field positions
`define AVR_UP_SPEED_HI      7
`define AVR_UP_SPEED_LO      6
`define AVR_UP_STEP_HI       5
`define AVR_UP_STEP_LO       4
`define AVR_DN_SPEED_HI      3
`define AVR_DN_SPEED_LO      2
`define AVR_DN_STEP_HI       1
`define AVR_DN_STEP_LO       0
`define AVR_EM_SPEED_HI      7
`define AVR_EM_SPEED_LO      6
`define AVR_EM_STEP_HI       5
`define AVR_EM_STEP_LO       4
// ==========================================================
// Reset values and constants
`define AVR_RST_VOL          8'h30
`define AVR_RST_RAMP_CFG     8'h22
`define AVR_RST_EMRG_CFG     8'h00
`define AVR_VOL_MUTE         8'hFF
`define AVR_SPEED_DIRECT     2'h3
`define AVR_STRAP_RESERVED   4'h8
// ==========================================================
// Timing
`define AVR_CLK_HZ           10000000
`define AVR_OT_CLEAR_US      1000
`define AVR_OC_CLEAR_US      1000
`define AVR_OT_CLEAR_CYC     ((`AVR_OT_CLEAR_US * (`AVR_CLK_HZ / 1000000)))
`define AVR_OC_CLEAR_CYC     ((`AVR_OC_CLEAR_US * (`AVR_CLK_HZ / 1000000)))
`endif

// ==== design/avr_pkg.sv ====
package avr_pkg;
  // ==========================================================
  // Register port request
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } avr_reg_req_type;
  // ==========================================================
  // Latched amplifier setup
  typedef struct packed {
    logic       reserved;
    logic       gain_high;
    logic [3:0] sw_mult;
    logic [2:0] code;
  } avr_amp_cfg_type;
  typedef enum logic [1:0] {
    AVR_LINK_INDEP  = 2'b00,
    AVR_LINK_A_FOLB = 2'b01,
    AVR_LINK_A_BOTH = 2'b10
  } avr_link_type;
  typedef enum logic [0:0] {
    AVR_STRAP_WAIT = 1'b0,
    AVR_STRAP_DONE = 1'b1
  } avr_strap_type;
endpackage

// ==== design/avr_top.sv ====
`include "avr_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module avr_top
  import avr_pkg::*;
#(
  parameter int OT_CLEAR_CYCLES = `AVR_OT_CLEAR_CYC,
  parameter int OC_CLEAR_CYCLES = `AVR_OC_CLEAR_CYC
) (
  input  wire logic            mclk,
  input  wire logic            arst_n,
  input  wire avr_reg_req_type reg_req,
  input  wire logic [1:0]      vol_link_mode,
  input  wire logic            fs_tick,
  input  wire logic            fs_family_44k,
  input  wire logic            clk_error,
  input  wire logic            supply_fail,
  input  wire logic            overtemp_error,
  input  wire logic            overcurrent_error,
  input  wire logic            strap_valid,
  input  wire logic [3:0]      gain_freq_strap_pin,
  output logic [7:0]           reg_rdata,
  output logic [7:0]           gain_a,
  output logic [7:0]           gain_b,
  output avr_amp_cfg_type      amp_cfg,
  output logic                 sync_family_44k,
  output logic                 amp_fault_out_n,
  output logic                 speaker_outputs_oe
);
  // ==========================================================
  // Helpers
  function automatic logic [7:0] step_size(input logic [1:0] c);
    step_size = 8'h08 >> c;
  endfunction
  function automatic logic due(input logic [1:0] sp, input logic [1:0] cnt);
    case (sp)
      2'h0:    due = 1'b1;
      2'h1:    due = ~cnt[0];
      2'h2:    due = (cnt == 2'h0);
      default: due = 1'b1;
    endcase
  endfunction
  function automatic logic [7:0] ramp(input logic [7:0] cur, input logic [7:0] tgt,
                                      input logic [1:0] upsp, input logic [1:0] upst,
                                      input logic [1:0] dnsp, input logic [1:0] dnst,
                                      input logic tick, input logic [1:0] cnt);
    logic [8:0] dn;
    logic [8:0] up;
    dn = {1'b0, cur} + {1'b0, step_size(dnst)};
    up = {1'b0, cur} - {1'b0, step_size(upst)};
    ramp = cur;
    if (tgt > cur) begin
      if (dnsp == `AVR_SPEED_DIRECT) begin
        ramp = tgt;
      end else if (tick && due(dnsp, cnt)) begin
        ramp = (dn >= {1'b0, tgt}) ? tgt : dn[7:0];
      end
    end else if (tgt < cur) begin
      if (upsp == `AVR_SPEED_DIRECT) begin
        ramp = tgt;
      end else if (tick && due(upsp, cnt)) begin
        ramp = (up[8] || up[7:0] <= tgt) ? tgt : up[7:0];
      end
    end
  endfunction
  // ==========================================================
  // Pin synchronisers
  logic [4:0] s1_q;
  logic [4:0] s2_q;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= 5'h00;
      s2_q <= 5'h00;
    end else begin
      s1_q <= {strap_valid, clk_error, supply_fail, overtemp_error, overcurrent_error};
      s2_q <= s1_q;
    end
  end
  logic [3:0] strap1_q;
  logic [3:0] strap2_q;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      strap1_q <= 4'h0;
      strap2_q <= 4'h0;
    end else begin
      strap1_q <= gain_freq_strap_pin;
      strap2_q <= strap1_q;
    end
  end
  logic emergency;
  assign emergency = s2_q[3] | s2_q[2];
  // ==========================================================
  // Registers
  logic [7:0] vol_a_q, vol_a_d, vol_b_q, vol_b_d;
  logic [7:0] ramp_cfg_q, ramp_cfg_d, emrg_cfg_q, emrg_cfg_d, rdata_d;
  always_comb begin
    vol_a_d    = vol_a_q;
    vol_b_d    = vol_b_q;
    ramp_cfg_d = ramp_cfg_q;
    emrg_cfg_d = emrg_cfg_q;
    if (reg_req.wr) begin
      case (reg_req.addr)
        `AVR_OFS_VOL_A:    vol_a_d    = reg_req.wdata;
        `AVR_OFS_VOL_B:    vol_b_d    = reg_req.wdata;
        `AVR_OFS_RAMP_CFG: ramp_cfg_d = reg_req.wdata;
        `AVR_OFS_EMRG_CFG: emrg_cfg_d = reg_req.wdata;
        default:           vol_a_d    = vol_a_q;
      endcase
    end
    case (reg_req.addr)
      `AVR_OFS_VOL_A:    rdata_d = vol_a_q;
      `AVR_OFS_VOL_B:    rdata_d = vol_b_q;
      `AVR_OFS_RAMP_CFG: rdata_d = ramp_cfg_q;
      `AVR_OFS_EMRG_CFG: rdata_d = emrg_cfg_q;
      default:           rdata_d = 8'h00;
    endcase
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      vol_a_q    <= `AVR_RST_VOL;
      vol_b_q    <= `AVR_RST_VOL;
      ramp_cfg_q <= `AVR_RST_RAMP_CFG;
      emrg_cfg_q <= `AVR_RST_EMRG_CFG;
      reg_rdata  <= 8'h00;
    end else begin
      vol_a_q    <= vol_a_d;
      vol_b_q    <= vol_b_d;
      ramp_cfg_q <= ramp_cfg_d;
      emrg_cfg_q <= emrg_cfg_d;
      reg_rdata  <= rdata_d;
    end
  end
  // ==========================================================
  // Volume ramp, gain codes 0 = +24 dB .. 48 = 0 dB .. 255 = mute
  logic [1:0] up_sp, up_st, dn_sp, dn_st, em_sp, em_st;
  assign up_sp = ramp_cfg_q[`AVR_UP_SPEED_HI:`AVR_UP_SPEED_LO];
  assign dn_sp = ramp_cfg_q[`AVR_DN_SPEED_HI:`AVR_DN_SPEED_LO];
  assign up_st = ramp_cfg_q[`AVR_UP_STEP_HI:`AVR_UP_STEP_LO];
  assign dn_st = ramp_cfg_q[`AVR_DN_STEP_HI:`AVR_DN_STEP_LO];
  assign em_sp = emrg_cfg_q[`AVR_EM_SPEED_HI:`AVR_EM_SPEED_LO];
  assign em_st = emrg_cfg_q[`AVR_EM_STEP_HI:`AVR_EM_STEP_LO];
  logic [7:0] tgt_a, tgt_b, gain_a_d, gain_b_d;
  logic [1:0] fs_cnt_q, fs_cnt_d;
  logic [1:0] r_dn_sp, r_dn_st;
  always_comb begin
    // Prohibited link code falls back to independent control
    case (vol_link_mode)
      AVR_LINK_A_FOLB: begin tgt_a = vol_b_q; tgt_b = vol_b_q; end
      AVR_LINK_A_BOTH: begin tgt_a = vol_a_q; tgt_b = vol_a_q; end
      default:         begin tgt_a = vol_a_q; tgt_b = vol_b_q; end
    endcase
    r_dn_sp = dn_sp;
    r_dn_st = dn_st;
    if (emergency) begin
      tgt_a   = `AVR_VOL_MUTE;
      tgt_b   = `AVR_VOL_MUTE;
      r_dn_sp = em_sp;
      r_dn_st = em_st;
    end
    fs_cnt_d = fs_tick ? fs_cnt_q + 2'h1 : fs_cnt_q;
    gain_a_d = ramp(gain_a, tgt_a, up_sp, up_st, r_dn_sp, r_dn_st, fs_tick, fs_cnt_q);
    gain_b_d = ramp(gain_b, tgt_b, up_sp, up_st, r_dn_sp, r_dn_st, fs_tick, fs_cnt_q);
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fs_cnt_q <= 2'h0;
      gain_a   <= `AVR_RST_VOL;
      gain_b   <= `AVR_RST_VOL;
    end else begin
      fs_cnt_q <= fs_cnt_d;
      gain_a   <= gain_a_d;
      gain_b   <= gain_b_d;
    end
  end
  // ==========================================================
  // Strap capture; taken once so later pin drift cannot move the gain
  avr_strap_type   strap_q, strap_d;
  avr_amp_cfg_type cfg_d;
  logic            fam_d;
  always_comb begin
    strap_d = strap_q;
    cfg_d   = amp_cfg;
    fam_d   = fs_family_44k;
    case (strap_q)
      AVR_STRAP_WAIT: begin
        if (s2_q[4]) begin
          strap_d           = AVR_STRAP_DONE;
          cfg_d.code        = strap2_q[2:0];
          cfg_d.reserved    = (strap2_q >= `AVR_STRAP_RESERVED);
          cfg_d.gain_high   = strap2_q[2];
          case (strap2_q[1:0])
            2'h3:    cfg_d.sw_mult = 4'h8;
            2'h2:    cfg_d.sw_mult = 4'h6;
            2'h1:    cfg_d.sw_mult = 4'h5;
            default: cfg_d.sw_mult = 4'h4;
          endcase
        end
      end
      AVR_STRAP_DONE: strap_d = AVR_STRAP_DONE;
      default:        strap_d = AVR_STRAP_WAIT;
    endcase
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      strap_q         <= AVR_STRAP_WAIT;
      amp_cfg         <= '0;
      sync_family_44k <= 1'b0;
    end else begin
      strap_q         <= strap_d;
      amp_cfg         <= cfg_d;
      sync_family_44k <= fam_d;
    end
  end
  // ==========================================================
  // Faults: timers reload while the fault stands, so retry waits a full clear time
  logic [31:0] ot_cnt_q, ot_cnt_d, oc_cnt_q, oc_cnt_d;
  logic        fault_d, oe_d;
  always_comb begin
    ot_cnt_d = s2_q[1] ? 32'(OT_CLEAR_CYCLES) :
               ((ot_cnt_q != 32'h0) ? ot_cnt_q - 32'h1 : 32'h0);
    oc_cnt_d = s2_q[0] ? 32'(OC_CLEAR_CYCLES) :
               ((oc_cnt_q != 32'h0) ? oc_cnt_q - 32'h1 : 32'h0);
    fault_d  = (ot_cnt_d != 0) || (oc_cnt_d != 0);
    oe_d     = !fault_d && (strap_q == AVR_STRAP_DONE) && !amp_cfg.reserved;
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ot_cnt_q           <= 32'h0;
      oc_cnt_q           <= 32'h0;
      amp_fault_out_n    <= 1'b1;
      speaker_outputs_oe <= 1'b0;
    end else begin
      ot_cnt_q           <= ot_cnt_d;
      oc_cnt_q           <= oc_cnt_d;
      amp_fault_out_n    <= !fault_d;
      speaker_outputs_oe <= oe_d;
    end
  end
endmodule
`default_nettype wire

// ==== tb/avr_top_chk_sva.sv ====
`timescale 1ns/1ns
`default_nettype none
module avr_top_chk
  import avr_pkg::*;
#(
  parameter int OT_CLEAR_CYCLES = 20,
  parameter int OC_CLEAR_CYCLES = 20
) (
  input wire logic            mclk,
  input wire logic            arst_n,
  input wire logic            fs_family_44k,
  input wire logic            clk_error,
  input wire logic            supply_fail,
  input wire logic            overtemp_error,
  input wire logic            overcurrent_error,
  input wire logic [7:0]      gain_a,
  input wire logic [7:0]      gain_b,
  input wire avr_amp_cfg_type amp_cfg,
  input wire logic            sync_family_44k,
  input wire logic            amp_fault_out_n,
  input wire logic            speaker_outputs_oe
);
  // =====
  // Protection and setup checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  a_ot_fault_out: assert property (overtemp_error[*4] |=> !amp_fault_out_n && !speaker_outputs_oe)
    else $error("overtemp left outputs on");
  a_oc_fault_out: assert property ($rose(overcurrent_error) ##1 overcurrent_error[*3] |=> !amp_fault_out_n)
    else $error("overcurrent gave no fault");
  a_fault_off_oe: assert property (!amp_fault_out_n |-> !speaker_outputs_oe)
    else $error("outputs driven during fault");
  a_reserved_off: assert property (amp_cfg.reserved |-> !speaker_outputs_oe)
    else $error("reserved band drives outputs");
  a_mult_decode: assert property (speaker_outputs_oe |-> amp_cfg.gain_high == amp_cfg.code[2] &&
    amp_cfg.sw_mult == (amp_cfg.code[1:0] == 2'h3 ? 4'h8 : 4'h4 + {2'h0, amp_cfg.code[1:0]}))
    else $error("strap decode wrong");
  a_strap_held: assert property (speaker_outputs_oe |=> $stable(amp_cfg))
    else $error("strap code changed");
  a_sync_family: assert property ($changed(fs_family_44k) |=> sync_family_44k == $past(fs_family_44k))
    else $error("sync family not followed");
  a_emerg_clk: assert property (clk_error[*4] |=> gain_a >= $past(gain_a) && gain_b >= $past(gain_b))
    else $error("gain rose in clock emergency");
  a_emerg_supply: assert property (supply_fail ##1 supply_fail[*3] |=> gain_b >= $past(gain_b))
    else $error("gain rose in supply emergency");
endmodule
bind avr_top avr_top_chk #(.OT_CLEAR_CYCLES(OT_CLEAR_CYCLES), .OC_CLEAR_CYCLES(OC_CLEAR_CYCLES)) u_chk (
  .mclk, .arst_n, .fs_family_44k, .clk_error, .supply_fail, .overtemp_error, .overcurrent_error,
  .gain_a, .gain_b, .amp_cfg, .sync_family_44k, .amp_fault_out_n, .speaker_outputs_oe);
`default_nettype wire

// ==== tb/avr_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module avr_host
  import avr_pkg::*;
(
  input  wire logic       mclk,
  output avr_reg_req_type reg_req,
  input  wire logic [7:0] reg_rdata
);
  // =====
  // Register access on the falling edge
  initial reg_req = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_req <= '{wr: 1'b1, addr: a, wdata: d};
    @(negedge mclk);
    reg_req.wr <= 1'b0;
    reg_req.wdata <= ~d;  // Stale data is never left on the bus
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_req.addr <= a;
    @(negedge mclk);
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb
  import avr_pkg::*;
;
  logic            mclk, arst_n, fs_tick, fs_fam, clk_err, sup_fail, ot, oc, fault_n, oe, sync_fam;
  logic [3:0]      strap;
  logic [1:0]      link;
  logic            strap_ok;
  logic [7:0]      rdata, rd_val, gain_a, gain_b, exp_a;
  avr_reg_req_type reg_req;
  avr_amp_cfg_type amp_cfg;
  int              errors = 0;
  int              n_tests = 0;
  int              cyc = 0;
  // =====
  // Clock, timeout, design and host
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      $display("ERROR %0t timeout", $time);
      final_report();
    end
  end
  avr_top #(.OT_CLEAR_CYCLES(20), .OC_CLEAR_CYCLES(20)) dut (.mclk(mclk), .arst_n(arst_n),
    .reg_req(reg_req), .vol_link_mode(link), .fs_tick(fs_tick), .fs_family_44k(fs_fam),
    .clk_error(clk_err), .supply_fail(sup_fail), .overtemp_error(ot), .overcurrent_error(oc),
    .strap_valid(strap_ok), .gain_freq_strap_pin(strap), .reg_rdata(rdata), .gain_a(gain_a),
    .gain_b(gain_b), .amp_cfg(amp_cfg), .sync_family_44k(sync_fam), .amp_fault_out_n(fault_n),
    .speaker_outputs_oe(oe));
  avr_host host (.mclk(mclk), .reg_req(reg_req), .reg_rdata(rdata));
  // =====
  // Shared tasks
  task automatic check(input logic [8:0] got, input logic [8:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(negedge mclk);
      fs_tick = 1'b1;
      @(negedge mclk);
      fs_tick = 1'b0;
    end
  endtask
  task automatic ramp(input logic [7:0] cfg, input int n, input logic [7:0] nxt);
    host.wr(8'h3F, cfg);
    tick(n);
    exp_a = nxt;
    check({1'b0, gain_a}, {1'b0, exp_a}, "ramp");
  endtask
  task automatic power_cycle();
    arst_n = 1'b0;
    repeat (6) @(negedge mclk);
    arst_n = 1'b1;
    repeat (6) @(negedge mclk);
  endtask
  task automatic final_report();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // =====
  // Scenarios
  initial begin
    {arst_n, fs_tick, fs_fam, clk_err, sup_fail, ot, oc, link} = '0;
    strap = 4'h5;
    strap_ok = 1'b1;
    power_cycle();
    check({1'b0, gain_a}, 9'h030, "gain reset");
    host.rd(8'h3F, rd_val);
    check({1'b0, rd_val}, 9'h022, "ramp cfg reset");
    host.rd(8'h40, rd_val);
    check({1'b0, rd_val}, 9'h000, "emergency cfg reset");
    host.wr(8'h77, 8'hA5);
    host.rd(8'h77, rd_val);
    check({1'b0, rd_val}, 9'h000, "unmapped");
    check(amp_cfg, 9'h0AD, "strap band 5");
    strap = 4'h2;
    tick(2);
    check(amp_cfg, 9'h0AD, "strap held");
    exp_a = 8'h30;
    host.wr(8'h3E, 8'hF0);
    for (int s = 0; s < 4; s++) ramp({6'h00, 2'(s)}, 1, exp_a + (8'h08 >> s));
    for (int r = 1; r < 3; r++) ramp({4'h0, 2'(r), 2'h0}, 2 * r, exp_a + 8'h08);
    ramp(8'h0C, 1, 8'hF0);
    host.wr(8'h3E, 8'h00);
    for (int s = 0; s < 4; s++) ramp({2'h0, 2'(s), 4'h0}, 1, exp_a - (8'h08 >> s));
    ramp(8'h40, 2, exp_a - 8'h08);
    ramp(8'hC0, 1, 8'h00);
    host.wr(8'h3E, 8'h04);
    ramp(8'h00, 1, 8'h04);
    // Emergency steps are checked on the untouched channel B
    for (int e = 0; e < 2; e++) begin
      host.wr(8'h40, e ? 8'h70 : 8'h00);
      {sup_fail, clk_err} = e ? 2'b10 : 2'b01;
      repeat (4) @(negedge mclk);
      tick(e + 1);
      check({1'b0, gain_b}, e ? 9'h039 : 9'h038, "emergency");
      {sup_fail, clk_err} = 2'b00;
    end
    // Direct ramp so each link target shows within a few edges
    host.wr(8'h3F, 8'hCC);
    for (int l = 1; l < 4; l++) begin
      link = 2'(l);
      repeat (3) @(negedge mclk);
      check({1'b0, gain_a}, l == 1 ? 9'h030 : 9'h004, "link gain a");
      check({1'b0, gain_b}, l == 2 ? 9'h004 : 9'h030, "link gain b");
    end
    link = 2'h0;
    for (int f = 0; f < 2; f++) begin
      {oc, ot} = f ? 2'b10 : 2'b01;
      repeat (6) @(negedge mclk);
      check({7'h0, fault_n, oe}, 9'h000, "fault on");
      {oc, ot} = 2'b00;
      repeat (30) @(negedge mclk);
      check({7'h0, fault_n, oe}, 9'h003, "fault clear");
    end
    fs_fam = 1'b1;
    repeat (2) @(negedge mclk);
    check({8'h0, sync_fam}, 9'h001, "sync family");
    power_cycle();
    check(amp_cfg, 9'h032, "strap band 2");
    strap = 4'h8;
    strap_ok = 1'b0;
    power_cycle();
    check(amp_cfg, 9'h000, "strap waits for valid");
    strap_ok = 1'b1;
    repeat (4) @(negedge mclk);
    check({7'h0, amp_cfg.reserved, oe}, 9'h002, "reserved band");
    final_report();
  end
endmodule
`default_nettype wire
